// File: sim/routing_fabric_model.sv
// Routing fabric model that sequences the datapath from the far side
`timescale 1ns/1ns
module routing_fabric_model (
	input  wire logic       clk,
	input  wire logic [2:0] word_sel,
	input  wire logic       carry_bit,
	output logic      [5:0] route_in
);
	// Quiet routing at time zero
	initial route_in = 6'h00;
	// Word select and carry launched just after each edge, serial ins low
	always @(posedge clk)
	begin
		route_in <= #1 {1'b0, carry_bit, 1'b0, word_sel};
	end
endmodule

// File: sim/tb_logic_tile_datapath.sv
// Self-checking bench for the logic tile datapath and its arrays
`timescale 1ns/1ns
module tb_logic_tile_datapath;
	logic         clk, reset, bus_wr, bus_rd, cfg_wr, chain_en, carry_bit;
	logic [2:0]   bus_addr, cfg_waddr, msb_pos, word_sel;
	logic [7:0]   bus_wdata, bus_rdata, or_mask, pla_out, pla_reg_sel, rd_val;
	logic [15:0]  cfg_wdata, cmp_mask;
	logic [5:0]   route_in, route_out;
	logic [23:0]  out_sel, pla_in;
	logic [1:0]   queue_out_mode;
	logic [3:0]   chain_in, chain_out;
	logic [191:0] and_t, and_c;
	logic [63:0]  or_map;
	int           n_errors, samples_checked, acc[2], dat[2], op, sh, mk, sa, sb, bv, e, k;

	logic_tile_datapath logic_tile_datapath_inst (.clk(clk), .reset(reset), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.cfg_wr(cfg_wr), .cfg_waddr(cfg_waddr), .cfg_wdata(cfg_wdata), .route_in(route_in),
		.route_out(route_out), .out_sel(out_sel), .msb_pos(msb_pos), .or_mask(or_mask),
		.cmp_mask(cmp_mask), .queue_out_mode(queue_out_mode), .chain_en(chain_en),
		.chain_in(chain_in), .chain_out(chain_out), .pla_in(pla_in), .pla_and_true(and_t),
		.pla_and_comp(and_c), .pla_or_map(or_map), .pla_reg_sel(pla_reg_sel), .pla_out(pla_out));
	routing_fabric_model routing_fabric_model_inst (.clk(clk), .word_sel(word_sel),
		.carry_bit(carry_bit), .route_in(route_in));

	// Free running clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Register result comparison
	task automatic chk_reg(input logic [7:0] x, input logic [7:0] o);
		samples_checked++;
		if (o !== x)
		begin
			n_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, x, o);
		end
	endtask
	// Routed output comparison
	task automatic chk_out(input logic [7:0] x, input logic [7:0] o);
		chk_reg(x, o);
	endtask
	// Bus write, one strobe cycle
	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge clk) #1;
		bus_addr = ad;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(posedge clk) #1;
		bus_wr = 1'b0;
	endtask
	// Bus read, data registered one cycle later
	task automatic rd(input logic [2:0] ad);
		@(posedge clk) #1;
		bus_addr = ad;
		bus_rd = 1'b1;
		@(posedge clk) #1;
		bus_rd = 1'b0;
		rd_val = bus_rdata;
	endtask
	// Bus write followed at once by a read, back to back
	task automatic wr_rd(input logic [2:0] aw, input logic [7:0] d, input logic [2:0] ar);
		@(posedge clk) #1;
		bus_addr = aw;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(posedge clk) #1;
		bus_wr = 1'b0;
		bus_addr = ar;
		bus_rd = 1'b1;
		@(posedge clk) #1;
		bus_rd = 1'b0;
		rd_val = bus_rdata;
	endtask
	// Configuration word write
	task automatic cfgw(input logic [2:0] ad, input logic [15:0] d);
		@(posedge clk) #1;
		cfg_waddr = ad;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(posedge clk) #1;
		cfg_wr = 1'b0;
	endtask
	// Run a configuration word for n cycles
	task automatic exec(input logic [2:0] s, input int n);
		@(posedge clk) #1;
		word_sel = s;
		repeat (n) @(posedge clk);
		#1 word_sel = 3'h0;
	endtask
	// Reference ALU followed by the shift unit
	function automatic int alu(int f, int s, int a, int b, int c, int m);
		int v;
		int w;
		w = (1 << (m + 1)) - 1;
		case (f)
			0: v = a;
			1: v = a + 1;
			2: v = a - 1;
			3: v = a + b + c;
			4: v = a - b - c;
			5: v = a & b;
			6: v = a | b;
			default: v = a ^ b;
		endcase
		v = v & w;
		if (s == 1) v = (v << 1) & w;
		if (s == 2) v = v >> 1;
		if (s == 3) v = ((v << 4) | (v >> 4)) & 255;
		return v;
	endfunction
	// Reference sum-of-products arrays
	function automatic logic [7:0] pla_model();
		logic [7:0]  o;
		logic [11:0] tr;
		logic [11:0] cp;
		logic [11:0] x;
		logic [7:0]  pt;
		o = 8'h00;
		for (int g = 0; g < 2; g++)
		begin
			x = pla_in[12 * g +: 12];
			for (int t = 0; t < 8; t++)
			begin
				tr = and_t[96 * g + 12 * t +: 12];
				cp = and_c[96 * g + 12 * t +: 12];
				pt[t] = ((tr | cp) != 0) && ((tr & ~x) == 0) && ((cp & x) == 0);
			end
			for (int q = 0; q < 4; q++)
				o[4 * g + q] = |(pt & or_map[32 * g + 8 * q +: 8]);
		end
		return o;
	endfunction
	// Verdict and end of run
	task automatic close_out();
		$display("checked=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		#(50 * 20000);
		n_errors++;
		close_out();
	end
	// Main sequence
	initial
	begin
		{bus_wr, bus_rd, cfg_wr, chain_en, carry_bit} = 5'h00;
		{bus_addr, cfg_waddr, word_sel, bus_wdata, cfg_wdata} = 33'h0;
		{chain_in, pla_in, and_t, and_c, or_map, pla_reg_sel} = 0;
		{msb_pos, or_mask, cmp_mask, out_sel} = {3'h7, 8'h00, 16'hFFFF, 24'h70CB64};
		queue_out_mode = 2'h2;
		reset = 1'b1;
		void'($urandom(32'h9F46));
		repeat (10) @(posedge clk);
		#1 reset = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			rd(3'(i));
			chk_reg((i == 6) ? 8'h05 : 8'h00, rd_val);
		end
		$display("test reset done");
		for (int i = 0; i < 32; i++)
		begin
			op = i % 8;
			sh = i / 8;
			mk = $urandom % 2;
			sa = $urandom % 2;
			sb = $urandom % 4;
			carry_bit = 1'($urandom % 2);
			or_mask = 8'($urandom);
			for (int j = 0; j < 2; j++)
			begin
				acc[j] = $urandom % 256;
				dat[j] = $urandom % 256;
				wr(3'(j), 8'(acc[j]));
				wr(3'(j + 2), 8'(dat[j]));
			end
			bv = (sb < 2) ? dat[sb] : acc[sb - 2];
			cfgw(3'h1, {2'h0, 1'(mk), 5'h01, 2'(sh), 2'(sb), 1'(sa), 3'(op)});
			exec(3'h1, 1);
			e = alu(op, sh, acc[sa], bv, carry_bit, 7) | (mk ? or_mask : 0);
			rd(3'h0);
			chk_reg(8'(e), rd_val);
			rd(3'h2);
			chk_reg(8'(dat[0]), rd_val);
		end
		msb_pos = 3'h3;
		wr(3'h0, 8'h0F);
		cfgw(3'h1, 16'h0101);
		exec(3'h1, 1);
		rd(3'h0);
		chk_reg(8'h00, rd_val);
		msb_pos = 3'h7;
		$display("test alu done");
		wr(3'h5, 8'hEE);
		wr_rd(3'h4, 8'h10, 3'h6);
		chk_reg(8'h04, rd_val);
		for (int i = 1; i < 5; i++)
			wr(3'h4, 8'(16 + i));
		rd(3'h6);
		chk_reg(8'h06, rd_val);
		rd(3'h4);
		chk_reg(8'h10, rd_val);
		cfgw(3'h3, 16'h0400);
		exec(3'h3, 5);
		rd(3'h2);
		chk_reg(8'h13, rd_val);
		wr(3'h0, 8'h40);
		cfgw(3'h2, 16'h0901);
		exec(3'h2, 5);
		rd(3'h6);
		chk_reg(8'h09, rd_val);
		for (int i = 1; i < 5; i++)
		begin
			rd(3'h5);
			chk_reg(8'(64 + i), rd_val);
		end
		rd(3'h0);
		chk_reg(8'h45, rd_val);
		$display("test queue done");
		for (int j = 0; j < 4; j++)
			wr(3'(j), (j % 2) ? 8'hFF : 8'h00);
		repeat (3) @(posedge clk);
		#1 chk_out(8'h35, {2'h0, route_out});
		chain_en = 1'b1;
		#1 chk_out(8'h00, {4'h0, chain_out});
		@(posedge clk) #1;
		chain_in = 4'hF;
		#1 chk_out(8'h07, {4'h0, chain_out});
		@(posedge clk) #1;
		chain_en = 1'b0;
		$display("test conditions done");
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk) #1;
			and_t = 0;
			and_c = 0;
			for (int j = 0; j < 16; j++)
			begin
				k = 12 * j + $urandom % 12;
				if ($urandom % 2)
					and_t[k] = 1'b1;
				else
					and_c[k] = 1'b1;
			end
			or_map = {$urandom, $urandom};
			pla_reg_sel = 8'($urandom);
			pla_in = 24'($urandom);
			@(posedge clk) #1;
			chk_out(pla_model(), pla_out);
		end
		$display("test arrays done");
		close_out();
	end
endmodule

// File: verilog/byte_queue.sv
// Four-byte queue held in flip-flops
`timescale 1ns/1ns
module byte_queue (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       push,
	input  wire logic [7:0] push_data,
	input  wire logic       pop,
	output logic      [7:0] head,
	output logic            full,
	output logic            empty
);
	logic [7:0] mem_reg [tile_pkg::QUEUE_DEPTH]; // Byte storage
	logic [1:0] wr_ptr_reg;                      // Next slot to fill
	logic [1:0] rd_ptr_reg;                      // Oldest slot
	logic [2:0] count_reg;                       // Occupancy
	logic       do_push;                         // Accepted push
	logic       do_pop;                          // Accepted pop

	// A push to a full queue or a pop from an empty one is dropped
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	assign full    = count_reg == tile_pkg::QUEUE_FULL;
	assign empty   = count_reg == tile_pkg::QUEUE_EMPTY;
	assign head    = mem_reg[rd_ptr_reg];

	// Storage write; cleared on reset so a peek of an empty queue reads a known byte
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < tile_pkg::QUEUE_DEPTH; i++)
				mem_reg[i] <= tile_pkg::WORK_RESET;
		end
		else if (do_push)
			mem_reg[wr_ptr_reg] <= push_data;
	end

	// Pointers and occupancy
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_ptr_reg <= tile_pkg::PTR_RESET;
			rd_ptr_reg <= tile_pkg::PTR_RESET;
			count_reg  <= tile_pkg::QUEUE_EMPTY;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + {1'b0, do_push};
			rd_ptr_reg <= rd_ptr_reg + {1'b0, do_pop};
			count_reg  <= count_reg + {2'h0, do_push} - {2'h0, do_pop};
		end
	end

	a_full_push_hold : assert property (@(posedge clk) disable iff (reset)
		full && push && !pop |=> full && $stable(wr_ptr_reg))
		else $error("push into full queue changed it");
	a_count_bound : assert property (@(posedge clk) disable iff (reset)
		count_reg <= tile_pkg::QUEUE_FULL)
		else $error("queue holds more than four bytes");
endmodule

// File: verilog/logic_tile_datapath.sv
// Logic tile top: two sum-of-products arrays and the 8-bit datapath
`timescale 1ns/1ns
module logic_tile_datapath (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [2:0]   bus_addr,
	input  wire logic         bus_wr,
	input  wire logic         bus_rd,
	input  wire logic [7:0]   bus_wdata,
	output logic      [7:0]   bus_rdata,
	input  wire logic         cfg_wr,
	input  wire logic [2:0]   cfg_waddr,
	input  wire logic [15:0]  cfg_wdata,
	input  wire logic [5:0]   route_in,
	output logic      [5:0]   route_out,
	input  wire logic [23:0]  out_sel,
	input  wire logic [2:0]   msb_pos,
	input  wire logic [7:0]   or_mask,
	input  wire logic [15:0]  cmp_mask,
	input  wire logic [1:0]   queue_out_mode,
	input  wire logic         chain_en,
	input  wire logic [3:0]   chain_in,
	output logic      [3:0]   chain_out,
	input  wire logic [23:0]  pla_in,
	input  wire logic [191:0] pla_and_true,
	input  wire logic [191:0] pla_and_comp,
	input  wire logic [63:0]  pla_or_map,
	input  wire logic [7:0]   pla_reg_sel,
	output logic      [7:0]   pla_out
);
	logic [7:0]  acc_reg [2];        // Accumulators
	logic [7:0]  dat_reg [2];        // Data registers
	logic [15:0] cfg_mem_reg [8];    // Configuration store
	logic [7:0]  bus_rdata_reg;      // Bus read data
	logic [5:0]  route_out_reg;      // Routed conditions
	logic        carry_reg;          // Registered carry
	logic        ovf_reg;            // Registered overflow
	logic        shout_reg;          // Registered shift out
	logic [2:0]  cfg_idx;            // Active word address
	logic [15:0] cw;                 // Active configuration word
	logic [7:0]  wm;                 // Width mask from msb position
	logic [7:0]  opa;                // ALU operand A
	logic [7:0]  opb;                // ALU operand B
	logic [8:0]  sum9;               // ALU result with carry
	logic [7:0]  alu_m;              // ALU result in width
	logic        carry;              // Carry or borrow out
	logic        ovf;                // Signed overflow
	logic [7:0]  sh;                 // Shift unit output
	logic        shout;              // Bit shifted out
	logic [7:0]  result;             // Final datapath result
	logic [1:0]  q_push;             // Queue push requests
	logic [1:0]  q_pop;              // Queue pop requests
	logic [1:0]  q_full;             // Queue full flags
	logic [1:0]  q_empty;            // Queue empty flags
	logic [1:0]  q_load;             // Input queue pops into tile
	logic [7:0]  q_din [2];          // Queue push data
	logic [7:0]  q_head [2];         // Queue oldest bytes
	logic [1:0]  cmp_eq;             // Chained compare equal
	logic [1:0]  cmp_lt;             // Compare less than
	logic [1:0]  zero;               // Zero detect
	logic [1:0]  ones;               // All ones detect
	logic [15:0] cond_vec;           // All conditions
	logic [7:0]  status;             // Status byte
	logic        sel0_cond;          // Condition picked for output 0

	// Mask of the bits at and below the chosen msb
	function automatic logic [7:0] width_mask(input logic [2:0] msb);
		logic [8:0] t;
		t = (9'h002 << msb) - 9'h001;
		return t[7:0];
	endfunction

	// Bus address match for a register index
	function automatic logic is_reg(input logic [2:0] addr, input logic [2:0] idx);
		return addr == idx;
	endfunction

	genvar g;
	// Two independent arrays
	for (g = 0; g < tile_pkg::PLA_N; g++)
	begin : g_pla
		sum_of_products_array u_array (
			.clk      (clk),
			.reset    (reset),
			.pla_in   (pla_in[g*12 +: 12]),
			.and_true (pla_and_true[g*96 +: 96]),
			.and_comp (pla_and_comp[g*96 +: 96]),
			.or_map   (pla_or_map[g*32 +: 32]),
			.reg_sel  (pla_reg_sel[g*4 +: 4]),
			.pla_out  (pla_out[g*4 +: 4])
		);
	end

	// Word zero is used while reset is held
	assign cfg_idx = reset ? tile_pkg::CFG_SEL_RESET : route_in[2:0];
	assign cw      = cfg_mem_reg[cfg_idx];
	assign wm      = width_mask(msb_pos);

	// Configuration store load
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < tile_pkg::CFG_WORDS; i++)
				cfg_mem_reg[i] <= tile_pkg::CFG_RESET;
		end
		else if (cfg_wr)
			cfg_mem_reg[cfg_waddr] <= cfg_wdata;
	end

	// Operand selection
	always_comb
	begin
		opa = acc_reg[cw[tile_pkg::CFG_SRCA]];
		unique case (cw[tile_pkg::CFG_SRCB_LSB +: 2])
			2'h0: opb = dat_reg[0];
			2'h1: opb = dat_reg[1];
			2'h2: opb = acc_reg[0];
			2'h3: opb = acc_reg[1];
		endcase
	end

	// ALU limited to the programmed width
	always_comb
	begin
		logic [8:0] a9;
		logic [8:0] b9;
		logic [8:0] c9;
		a9 = {1'b0, opa & wm};
		b9 = {1'b0, opb & wm};
		c9 = {8'h00, route_in[tile_pkg::ROUTE_CARRY_IN]};
		unique case (tile_pkg::alu_op_t'(cw[tile_pkg::CFG_FUNC_LSB +: 3]))
			tile_pkg::OP_PASS: sum9 = a9;
			tile_pkg::OP_INC:  sum9 = a9 + 9'h001;
			tile_pkg::OP_DEC:  sum9 = a9 - 9'h001;
			tile_pkg::OP_ADD:  sum9 = a9 + b9 + c9;
			tile_pkg::OP_SUB:  sum9 = a9 - b9 - c9;
			tile_pkg::OP_AND:  sum9 = a9 & b9;
			tile_pkg::OP_OR:   sum9 = a9 | b9;
			tile_pkg::OP_XOR:  sum9 = a9 ^ b9;
		endcase
		alu_m = sum9[7:0] & wm;
		carry = sum9[{1'b0, msb_pos} + 4'h1];
		// Overflow from operand and result signs at the msb
		unique case (tile_pkg::alu_op_t'(cw[tile_pkg::CFG_FUNC_LSB +: 3]))
			tile_pkg::OP_ADD: ovf = (opa[msb_pos] == opb[msb_pos])
				&& (alu_m[msb_pos] != opa[msb_pos]);
			tile_pkg::OP_SUB: ovf = (opa[msb_pos] != opb[msb_pos])
				&& (alu_m[msb_pos] != opa[msb_pos]);
			default: ovf = 1'b0;
		endcase
	end

	// Shift, swap and mask follow any ALU function
	always_comb
	begin
		sh    = alu_m;
		shout = 1'b0;
		unique case (tile_pkg::shift_op_t'(cw[tile_pkg::CFG_SHIFT_LSB +: 2]))
			tile_pkg::SH_PASS: sh = alu_m;
			tile_pkg::SH_LEFT:
			begin
				sh    = ((alu_m << 1) | {7'h00, route_in[tile_pkg::ROUTE_SHIFT_LOW]}) & wm;
				shout = alu_m[msb_pos];
			end
			tile_pkg::SH_RIGHT:
			begin
				sh    = (alu_m >> 1)
					| ({7'h00, route_in[tile_pkg::ROUTE_SHIFT_HIGH]} << msb_pos);
				shout = alu_m[0];
			end
			tile_pkg::SH_SWAP: sh = {alu_m[3:0], alu_m[7:4]};
		endcase
		result = cw[tile_pkg::CFG_MASK_EN] ? (sh | or_mask) : sh;
	end

	// Queues: input mode filled by bus, output mode filled by datapath
	for (g = 0; g < 2; g++)
	begin : g_queue
		localparam logic [2:0] QI = tile_pkg::REG_Q0 + 3'(g);
		assign q_load[g] = cw[tile_pkg::CFG_Q0_STEP + g] && !queue_out_mode[g]
			&& !q_empty[g];
		assign q_push[g] = queue_out_mode[g] ? cw[tile_pkg::CFG_Q0_STEP + g]
			: (bus_wr && is_reg(bus_addr, QI));
		assign q_pop[g]  = queue_out_mode[g] ? (bus_rd && is_reg(bus_addr, QI))
			: q_load[g];
		assign q_din[g]  = !queue_out_mode[g] ? bus_wdata
			: (cw[tile_pkg::CFG_Q_SRC] ? acc_reg[g] : result);
		byte_queue u_queue (
			.clk       (clk),
			.reset     (reset),
			.push      (q_push[g]),
			.push_data (q_din[g]),
			.pop       (q_pop[g]),
			.head      (q_head[g]),
			.full      (q_full[g]),
			.empty     (q_empty[g])
		);
	end

	// Accumulators: bus write first, then ALU result or queue byte
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			acc_reg[0] <= tile_pkg::WORK_RESET;
			acc_reg[1] <= tile_pkg::WORK_RESET;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (bus_wr && is_reg(bus_addr, tile_pkg::REG_ACC0 + 3'(i)))
					acc_reg[i] <= bus_wdata;
				else if (cw[tile_pkg::CFG_WR_ACC0 + i])
				begin
					if (cw[tile_pkg::CFG_Q_SRC] && !queue_out_mode[i])
					begin
						if (q_load[i])
							acc_reg[i] <= q_head[i];
					end
					else
						acc_reg[i] <= result;
				end
			end
		end
	end

	// Data registers: bus write or input queue byte only
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dat_reg[0] <= tile_pkg::WORK_RESET;
			dat_reg[1] <= tile_pkg::WORK_RESET;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (bus_wr && is_reg(bus_addr, tile_pkg::REG_DAT0 + 3'(i)))
					dat_reg[i] <= bus_wdata;
				else if (q_load[i] && !cw[tile_pkg::CFG_Q_SRC])
					dat_reg[i] <= q_head[i];
			end
		end
	end

	// ALU flags registered every cycle for use in the next cycle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			carry_reg <= 1'b0;
			ovf_reg   <= 1'b0;
			shout_reg <= 1'b0;
		end
		else
		begin
			carry_reg <= carry;
			ovf_reg   <= ovf;
			shout_reg <= shout;
		end
	end

	// Compares and detects; both equal compares and the accumulator 0 zero and ones detects chained when enabled
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			logic [7:0] cb;
			cb = cw[tile_pkg::CFG_CMP0_B + i] ? acc_reg[1 - i] : dat_reg[i];
			cmp_eq[i] = ((acc_reg[i] & cmp_mask[i*8 +: 8]) == (cb & cmp_mask[i*8 +: 8]))
				&& (!chain_en || chain_in[i]);
			cmp_lt[i] = (acc_reg[i] & cmp_mask[i*8 +: 8]) < (cb & cmp_mask[i*8 +: 8]);
			zero[i]   = (acc_reg[i] & wm) == 8'h00;
			ones[i]   = (acc_reg[i] & wm) == wm;
		end
		zero[0] = zero[0] && (!chain_en || chain_in[2]);
		ones[0] = ones[0] && (!chain_en || chain_in[3]);
	end

	assign chain_out = {ones[0], zero[0], cmp_eq[1], cmp_eq[0]};

	// Condition vector, queue flags included
	always_comb
	begin
		cond_vec = 16'h0000;
		for (int i = 0; i < 2; i++)
		begin
			cond_vec[tile_pkg::COND_CMP0_EQ + 2*i]      = cmp_eq[i];
			cond_vec[tile_pkg::COND_CMP0_EQ + 2*i + 1]  = cmp_lt[i];
			cond_vec[tile_pkg::COND_ZERO0 + i]          = zero[i];
			cond_vec[tile_pkg::COND_ONES0 + i]          = ones[i];
			cond_vec[tile_pkg::COND_Q0_EMPTY + 2*i]     = q_empty[i];
			cond_vec[tile_pkg::COND_Q0_EMPTY + 2*i + 1] = q_full[i];
		end
		cond_vec[tile_pkg::COND_OVF]     = ovf_reg;
		cond_vec[tile_pkg::COND_CARRY]   = carry_reg;
		cond_vec[tile_pkg::COND_SHOUT]   = shout_reg;
		cond_vec[tile_pkg::COND_BOTH_EQ] = cmp_eq[0] && cmp_eq[1];
	end

	// Six routed outputs, each picks one condition
	always_ff @(posedge clk)
	begin
		if (reset)
			route_out_reg <= 6'h00;
		else
			for (int k = 0; k < tile_pkg::ROUTE_W; k++)
				route_out_reg[k] <= cond_vec[out_sel[k*4 +: 4]];
	end

	assign status = {4'h0, q_full[1], q_empty[1], q_full[0], q_empty[0]};

	// Bus read data, one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (reset)
			bus_rdata_reg <= 8'h00;
		else if (bus_rd)
		begin
			unique case (bus_addr)
				3'h0, 3'h1: bus_rdata_reg <= acc_reg[bus_addr[0]];
				3'h2, 3'h3: bus_rdata_reg <= dat_reg[bus_addr[0]];
				3'h4, 3'h5: bus_rdata_reg <= q_head[bus_addr[0]];
				tile_pkg::REG_STATUS: bus_rdata_reg <= status;
				default: bus_rdata_reg <= 8'h00;
			endcase
		end
	end

	assign bus_rdata = bus_rdata_reg;
	assign route_out = route_out_reg;
	assign sel0_cond = cond_vec[out_sel[3:0]];

	default clocking cb_main @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_push_q0;
		bus_wr && is_reg(bus_addr, tile_pkg::REG_Q0) && !queue_out_mode[0];
	endsequence
	sequence s_read_status;
		bus_rd && is_reg(bus_addr, tile_pkg::REG_STATUS);
	endsequence

	a_reset_clear : assert property (@(posedge clk) disable iff (1'b0)
		reset |=> acc_reg[0] == 8'h00 && acc_reg[1] == 8'h00 && dat_reg[0] == 8'h00
			&& q_empty == 2'h3)
		else $error("reset left working state set");
	a_acc_result : assert property (
		cw[tile_pkg::CFG_WR_ACC0] && !cw[tile_pkg::CFG_Q_SRC]
		&& !(bus_wr && is_reg(bus_addr, tile_pkg::REG_ACC0)) |=> acc_reg[0] == $past(result))
		else $error("accumulator missed the datapath result");
	a_data_protect : assert property (
		!(bus_wr && is_reg(bus_addr, tile_pkg::REG_DAT0)) && !q_load[0] |=> $stable(dat_reg[0]))
		else $error("data register changed without a load");
	a_route_select : assert property (
		!$past(reset) |-> route_out[0] == $past(sel0_cond))
		else $error("routed output does not show selected condition");
	a_bus_read : assert property (
		bus_rd && is_reg(bus_addr, tile_pkg::REG_ACC0) |=> bus_rdata == $past(acc_reg[0]))
		else $error("bus read of accumulator returned wrong data");
	a_zero_flag : assert property (
		bus_wr && is_reg(bus_addr, tile_pkg::REG_ACC0) && bus_wdata == 8'h00 && !chain_en
		##1 !chain_en |-> cond_vec[tile_pkg::COND_ZERO0])
		else $error("zero detect missed a cleared accumulator");
	a_queue_status : assert property (
		s_push_q0 ##1 s_read_status |=> !bus_rdata[tile_pkg::STAT_Q0_EMPTY])
		else $error("queue still empty after bus write");
endmodule

// File: verilog/sum_of_products_array.sv
// One small sum-of-products array with optional output registers
`timescale 1ns/1ns
module sum_of_products_array (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [11:0] pla_in,
	input  wire logic [95:0] and_true,
	input  wire logic [95:0] and_comp,
	input  wire logic [31:0] or_map,
	input  wire logic [3:0]  reg_sel,
	output logic      [3:0]  pla_out
);
	logic [7:0] term;     // Product terms
	logic [3:0] comb_out; // Sums before the registers
	logic [3:0] out_reg;  // Registered sums

	genvar t, k;
	// Each term ANDs its chosen true or complement inputs; empty term is 0
	for (t = 0; t < tile_pkg::PLA_PT; t++)
	begin : g_term
		logic [11:0] tv;
		logic [11:0] cv;
		assign tv = and_true[t*12 +: 12];
		assign cv = and_comp[t*12 +: 12];
		assign term[t] = (|(tv | cv)) && (&((pla_in | ~tv) & (~pla_in | ~cv)));
	end
	// Each output ORs any of the eight shared terms
	for (k = 0; k < tile_pkg::PLA_OUT; k++)
	begin : g_sum
		assign comb_out[k] = |(term & or_map[k*8 +: 8]);
	end

	// Output registers
	always_ff @(posedge clk)
	begin
		if (reset)
			out_reg <= 4'h0;
		else
			out_reg <= comb_out;
	end

	// Per output choice of registered or combinational
	assign pla_out = (reg_sel & out_reg) | (~reg_sel & comb_out);

	a_pla_reg_out : assert property (@(posedge clk) disable iff (reset)
		reg_sel[0] && !$past(reset) |-> pla_out[0] == $past(comb_out[0]))
		else $error("registered array output does not follow its sum");
endmodule

// File: verilog/tile_pkg.sv
// Shared constants and types for the configurable logic tile
package tile_pkg;
	localparam int DATA_W      = 8;  // Datapath width
	localparam int CFG_WORDS   = 8;  // Configuration words
	localparam int CFG_W       = 16; // Bits per configuration word
	localparam int PLA_IN      = 12; // Inputs per array
	localparam int PLA_PT      = 8;  // Product terms per array
	localparam int PLA_OUT     = 4;  // Outputs per array
	localparam int PLA_N       = 2;  // Arrays per tile
	localparam int ROUTE_W     = 6;  // Routing inputs and outputs
	localparam int COND_N      = 16; // Condition vector size
	localparam int QUEUE_DEPTH = 4;  // Bytes per queue
	// Queue occupancy marks
	localparam logic [2:0] QUEUE_FULL  = 3'h4;
	localparam logic [2:0] QUEUE_EMPTY = 3'h0;
	// Register indices on the system bus
	localparam logic [2:0] REG_ACC0   = 3'h0;
	localparam logic [2:0] REG_DAT0   = 3'h2;
	localparam logic [2:0] REG_Q0     = 3'h4;
	localparam logic [2:0] REG_STATUS = 3'h6;
	// Status bits: queue i empty at 2i, full at 2i+1
	localparam int STAT_Q0_EMPTY = 0;
	localparam int STAT_Q0_FULL  = 1;
	// Configuration word fields
	localparam int CFG_FUNC_LSB  = 0;  // ALU function, 3 bits
	localparam int CFG_SRCA      = 3;  // Operand A: accumulator 0 or 1
	localparam int CFG_SRCB_LSB  = 4;  // Operand B: dat0, dat1, acc0, acc1
	localparam int CFG_SHIFT_LSB = 6;  // Shift unit, 2 bits
	localparam int CFG_WR_ACC0   = 8;  // Accumulator write enables, 2 bits
	localparam int CFG_Q0_STEP   = 10; // Queue steps, 2 bits
	localparam int CFG_Q_SRC     = 12; // Queue moves with accumulators
	localparam int CFG_MASK_EN   = 13; // OR mask on the result
	localparam int CFG_CMP0_B    = 14; // Compare B: data reg or other acc, 2 bits
	// Routing input positions
	localparam int ROUTE_SHIFT_LOW  = 3;
	localparam int ROUTE_CARRY_IN   = 4;
	localparam int ROUTE_SHIFT_HIGH = 5;
	// Condition indices
	localparam int COND_CMP0_EQ  = 0;  // Compare i equal at 2i, less at 2i+1
	localparam int COND_ZERO0    = 4;  // Zero detect, +i
	localparam int COND_ONES0    = 6;  // All ones detect, +i
	localparam int COND_OVF      = 8;
	localparam int COND_CARRY    = 9;
	localparam int COND_SHOUT    = 10;
	localparam int COND_Q0_EMPTY = 11; // Queue i empty at 11+2i, full at 12+2i
	localparam int COND_BOTH_EQ  = 15;
	// Reset values
	localparam logic [7:0]  WORK_RESET    = 8'h00;
	localparam logic [15:0] CFG_RESET     = 16'h0000;
	localparam logic [2:0]  CFG_SEL_RESET = 3'h0;
	localparam logic [1:0]  PTR_RESET     = 2'h0;
	typedef enum logic [2:0] {
		OP_PASS = 3'h0, OP_INC = 3'h1, OP_DEC = 3'h2, OP_ADD = 3'h3,
		OP_SUB  = 3'h4, OP_AND = 3'h5, OP_OR  = 3'h6, OP_XOR = 3'h7
	} alu_op_t;
	typedef enum logic [1:0] {
		SH_PASS = 2'h0, SH_LEFT = 2'h1, SH_RIGHT = 2'h2, SH_SWAP = 2'h3
	} shift_op_t;
endpackage
